// ===== rtl/ubf_regs.svh
/*
 * Register indices, field positions, reset values and timing figures of the
 * UART baud and line configuration block.
 * Assumes an APB slave with 32-bit data; each index is one word, byte address = 4 * index.
 */
`ifndef UBF_REGS_SVH
`define UBF_REGS_SVH

// printed offsets are register indices
`define UBF_IDX_DATA 16'h449E
`define UBF_IDX_STATUS 16'h44A4
`define UBF_IDX_LINE_CONFIG 16'h44AE
`define UBF_IDX_BAUD_PERIOD 16'h44B4
`define UBF_IDX_BAUD_FRACTION 16'h44B6

// line_config fields
`define UBF_CFG_MANUAL_RTS 0
`define UBF_CFG_EIGHT_BIT 1
`define UBF_CFG_TWO_STOP 2
`define UBF_CFG_PARITY_EN 3
`define UBF_CFG_ODD_PARITY 4
`define UBF_CFG_FLOW_EN 5
`define UBF_CFG_AUTO_RTS 6
`define UBF_CFG_MASK 7'h7F

// status fields
`define UBF_ST_CTS 0
`define UBF_ST_RX_VALID 1
`define UBF_ST_TX_FREE 2
`define UBF_ST_RX_OVF 3
`define UBF_ST_FRM_ERR 4
`define UBF_ST_PAR_ERR 5
`define UBF_ST_TX_IDLE 6

`define UBF_RST_CONFIG 7'h00
`define UBF_RST_PERIOD 16'h0000
`define UBF_RST_FRACTION 1'b0

// reference clock for the rate equation and the bus clock, in MHz
`define UBF_REF_MHZ 24
`define UBF_PCLK_MHZ 25

`define UBF_RX_DEPTH 4

`endif

// ===== rtl/ubf_pkg.sv
/*
 * Types of the UART baud and line configuration block.
 * Assumes ubf_regs.svh supplies the numeric constants.
 */
package ubf_pkg;
  typedef enum logic [0:0] {
    UBF_TX_IDLE = 1'b0,
    UBF_TX_SEND = 1'b1
  } ubf_tx_state_t;

  typedef enum logic [1:0] {
    UBF_RX_IDLE = 2'b00,
    UBF_RX_START = 2'b01,
    UBF_RX_BITS = 2'b10,
    UBF_RX_STOP = 2'b11
  } ubf_rx_state_t;
endpackage

// ===== rtl/ubf_top.sv
/*
 * UART with programmable baud period and fraction, parity, stop bits,
 * data width and request/clear-to-send flow control, behind an APB slave.
 * Assumes pclk at 25 MHz, pin inputs synchronous to pclk, and software
 * reading received characters from the data register.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ubf_regs.svh"

// Notes on behaviour
// - fraction bit adds half count to period
// - 16-bit baud period N in rate equation
// - auto mode: hardware drives rx_ready_out_n
// - auto: deassert when one slot left
// - auto: reassert when more slots free
// - auto mode ignores manual_rts_level
// - manual: level set asserts output low
// - flow_handshake_enable enables tx_permit_in_n only; rx_ready_out_n is driven either way
// - handshake off: transmitter always permitted
// - odd_parity_select picks odd, else even
module ubf_top
  import ubf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_in,
  output logic tx_out,
  input wire logic tx_permit_in_n,
  output logic rx_ready_out_n
);

  localparam int DEPTH = `UBF_RX_DEPTH;
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction

  // even parity makes the total count of ones even
  function automatic logic par_bit(input logic [7:0] d, input logic eight, input logic odd);
    par_bit = ^(eight ? d : {1'b0, d[6:0]}) ^ odd;
  endfunction

  logic [6:0] cfg_q, cfg_d;
  logic [15:0] per_q, per_d;
  logic [2:0] err_q, err_d, err_set, cnt_q, cnt_d;
  logic [31:0] rdata_q, rdata_d, status;
  logic frac_q, frac_d, ready_q, ready_d, slverr_q, slverr_d, thr_full_q, thr_full_d;
  logic rts_n_q, rts_n_d, tick_q, tick_d, tx_q, tx_d;
  logic [7:0] thr_q, thr_d, rx_char;
  logic [7:0] fifo_q [DEPTH];
  logic [1:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
  logic [5:0] acc_q, acc_d;
  ubf_tx_state_t tx_st_q, tx_st_d;
  logic [11:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_left_q, tx_left_d, rx_idx_q, rx_idx_d, nbits;
  logic [16:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d, bit_ticks;
  ubf_rx_state_t rx_st_q, rx_st_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic acc_done, wr_en, rd_en, cts_ok, push, pop;

  assign acc_done = psel && penable && ready_q;
  assign wr_en = acc_done && pwrite;
  assign rd_en = acc_done && !pwrite;
  // bit time in 24 MHz ticks: 2N + F
  assign bit_ticks = {per_q, frac_q};
  assign cts_ok = !cfg_q[`UBF_CFG_FLOW_EN] || !tx_permit_in_n;
  assign nbits = cfg_q[`UBF_CFG_EIGHT_BIT] ? 4'd8 : 4'd7;
  assign pop = rd_en && hit(paddr, `UBF_IDX_DATA) && (cnt_q != 3'd0);
  assign status = {25'h0000000, tx_st_q == UBF_TX_IDLE && !thr_full_q, err_q,
                   !thr_full_q, cnt_q != 3'd0, cts_ok};

  // registers and bus answer; one wait state per transfer
  always_comb begin
    cfg_d = cfg_q;
    per_d = per_q;
    frac_d = frac_q;
    rdata_d = rdata_q;
    ready_d = psel && penable && !ready_q;
    slverr_d = 1'b0;
    if (psel && penable && !ready_q) begin
      rdata_d = 32'h00000000;
      if (hit(paddr, `UBF_IDX_LINE_CONFIG)) rdata_d = {25'h0000000, cfg_q};
      else if (hit(paddr, `UBF_IDX_BAUD_PERIOD)) rdata_d = {16'h0000, per_q};
      else if (hit(paddr, `UBF_IDX_BAUD_FRACTION)) rdata_d = {31'h00000000, frac_q};
      else if (hit(paddr, `UBF_IDX_STATUS)) rdata_d = status;
      else if (hit(paddr, `UBF_IDX_DATA)) rdata_d = {24'h000000, fifo_q[rd_ptr_q]};
      else slverr_d = 1'b1;
    end
    if (wr_en) begin
      if (hit(paddr, `UBF_IDX_LINE_CONFIG)) cfg_d = pwdata[6:0] & `UBF_CFG_MASK;
      if (hit(paddr, `UBF_IDX_BAUD_PERIOD)) per_d = pwdata[15:0];
      if (hit(paddr, `UBF_IDX_BAUD_FRACTION)) frac_d = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `UBF_RST_CONFIG;
      per_q <= `UBF_RST_PERIOD;
      frac_q <= `UBF_RST_FRACTION;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      per_q <= per_d;
      frac_q <= frac_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      slverr_q <= slverr_d;
    end
  end

  // 24 MHz ticks from pclk by accumulator; six bits so that 24 + 24 never wraps
  always_comb begin
    acc_d = acc_q + 6'(`UBF_REF_MHZ);
    tick_d = 1'b0;
    if (acc_d >= 6'(`UBF_PCLK_MHZ)) begin
      acc_d = acc_d - 6'(`UBF_PCLK_MHZ);
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  // transmitter: one holding byte, then a frame shifted out lsb first
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_cnt_d = tx_cnt_q;
    thr_d = thr_q;
    thr_full_d = thr_full_q;
    tx_d = tx_q;
    if (wr_en && hit(paddr, `UBF_IDX_DATA) && !thr_full_q) begin
      thr_d = pwdata[7:0];
      thr_full_d = 1'b1;
    end
    unique case (tx_st_q)
      UBF_TX_IDLE: begin
        tx_d = 1'b1;
        if (thr_full_q && cts_ok) begin
          tx_sh_d = 12'hFFF;
          tx_sh_d[8:0] = {thr_q, 1'b0};
          if (!cfg_q[`UBF_CFG_EIGHT_BIT]) tx_sh_d[8] = 1'b1;
          if (cfg_q[`UBF_CFG_PARITY_EN])
            tx_sh_d[nbits + 4'd1] = par_bit(thr_q, cfg_q[`UBF_CFG_EIGHT_BIT],
                                            cfg_q[`UBF_CFG_ODD_PARITY]);
          tx_left_d = 4'd2 + nbits + {3'b000, cfg_q[`UBF_CFG_PARITY_EN]}
                      + {3'b000, cfg_q[`UBF_CFG_TWO_STOP]};
          tx_cnt_d = 17'h00000;
          thr_full_d = 1'b0;
          tx_st_d = UBF_TX_SEND;
        end
      end
      UBF_TX_SEND: begin
        tx_d = tx_sh_q[0];
        if (tick_q) begin
          if (tx_cnt_q + 17'h00001 >= bit_ticks) begin
            tx_cnt_d = 17'h00000;
            tx_sh_d = {1'b1, tx_sh_q[11:1]};
            tx_left_d = tx_left_q - 4'd1;
            if (tx_left_q == 4'd1) tx_st_d = UBF_TX_IDLE;
          end else begin
            tx_cnt_d = tx_cnt_q + 17'h00001;
          end
        end
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= UBF_TX_IDLE;
      tx_sh_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_cnt_q <= 17'h00000;
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_cnt_q <= tx_cnt_d;
      thr_q <= thr_d;
      thr_full_q <= thr_full_d;
      tx_q <= tx_d;
    end
  end

  // receiver: sample mid-bit, N ticks after the start edge
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_idx_d = rx_idx_q;
    rx_cnt_d = rx_cnt_q;
    push = 1'b0;
    err_set = 3'b000;
    rx_char = cfg_q[`UBF_CFG_EIGHT_BIT] ? rx_sh_q[7:0] : {1'b0, rx_sh_q[6:0]};
    if (tick_q && rx_st_q != UBF_RX_IDLE) rx_cnt_d = rx_cnt_q + 17'h00001;
    unique case (rx_st_q)
      UBF_RX_IDLE: begin
        rx_cnt_d = 17'h00000;
        if (!rx_in) rx_st_d = UBF_RX_START;
      end
      UBF_RX_START: begin
        if (tick_q && rx_cnt_q + 17'h00001 >= {1'b0, per_q}) begin
          rx_cnt_d = 17'h00000;
          rx_idx_d = 4'd0;
          rx_st_d = rx_in ? UBF_RX_IDLE : UBF_RX_BITS;
        end
      end
      UBF_RX_BITS: begin
        if (tick_q && rx_cnt_q + 17'h00001 >= bit_ticks) begin
          rx_cnt_d = 17'h00000;
          rx_sh_d[rx_idx_q] = rx_in;
          rx_idx_d = rx_idx_q + 4'd1;
          if (rx_idx_q + 4'd1 == nbits + {3'b000, cfg_q[`UBF_CFG_PARITY_EN]})
            rx_st_d = UBF_RX_STOP;
        end
      end
      UBF_RX_STOP: begin
        if (tick_q && rx_cnt_q + 17'h00001 >= bit_ticks) begin
          rx_st_d = UBF_RX_IDLE;
          push = 1'b1;
          err_set[1] = !rx_in;
          err_set[2] = cfg_q[`UBF_CFG_PARITY_EN] && (rx_sh_q[nbits] != par_bit(rx_char,
                       cfg_q[`UBF_CFG_EIGHT_BIT], cfg_q[`UBF_CFG_ODD_PARITY]));
          if (cnt_q == 3'(DEPTH)) begin
            push = 1'b0;
            err_set[0] = 1'b1;
          end
        end
      end
    endcase
    // sticky errors: write one to clear, a new error wins over the clear
    err_d = err_q;
    if (wr_en && hit(paddr, `UBF_IDX_STATUS)) err_d = err_q & ~pwdata[5:3];
    err_d = err_d | err_set;
    rd_ptr_d = rd_ptr_q + {1'b0, pop};
    wr_ptr_d = wr_ptr_q + {1'b0, push};
    cnt_d = cnt_q + {2'b00, push} - {2'b00, pop};
    // one free slot left means the peer must stop
    if (cfg_q[`UBF_CFG_AUTO_RTS])
      rts_n_d = (3'(DEPTH) - cnt_d) <= 3'd1;
    else
      rts_n_d = !cfg_q[`UBF_CFG_MANUAL_RTS];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= UBF_RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_cnt_q <= 17'h00000;
      err_q <= 3'b000;
      rd_ptr_q <= 2'b00;
      wr_ptr_q <= 2'b00;
      cnt_q <= 3'b000;
      rts_n_q <= 1'b1;
      for (int i = 0; i < DEPTH; i++) fifo_q[i] <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_idx_q <= rx_idx_d;
      rx_cnt_q <= rx_cnt_d;
      err_q <= err_d;
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= wr_ptr_d;
      cnt_q <= cnt_d;
      rts_n_q <= rts_n_d;
      if (push) fifo_q[wr_ptr_q] <= rx_char;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = slverr_q;
  assign tx_out = tx_q;
  assign rx_ready_out_n = rts_n_q;
endmodule
`default_nettype wire

// ===== test/ubf_top_assertions.sv
/* Port checker for the UART config block: bus timing, readback, rts, flow.
   Assumes it is bound to ubf_top. */
`timescale 1ns/10ps
`default_nettype none
`include "ubf_regs.svh"
module ubf_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_in,
  input wire logic tx_out,
  input wire logic tx_permit_in_n,
  input wire logic rx_ready_out_n
);
  wire [15:0] idx = paddr[17:2];
  wire rd = pready && !pwrite;
  wire wr_cfg = pready && pwrite && idx == `UBF_IDX_LINE_CONFIG;
  logic [6:0] cfg_q;
  logic [1:0] stab_q;
  // stab_q lets the registered pin settle after a config write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 7'h00;
      stab_q <= 2'h0;
    end else begin
      if (wr_cfg) cfg_q <= pwdata[6:0];
      stab_q <= wr_cfg ? 2'h0 : (stab_q == 2'h3 ? stab_q : stab_q + 2'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer one cycle into access");
  a_pulse_once: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_qual: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_frac_width: assert property (
    rd && idx == `UBF_IDX_BAUD_FRACTION |-> prdata[31:1] == 31'h0) else $error("fraction width");
  a_period_width: assert property (
    rd && idx == `UBF_IDX_BAUD_PERIOD |-> prdata[31:16] == 16'h0) else $error("period width");
  a_cfg_mirror: assert property (
    rd && idx == `UBF_IDX_LINE_CONFIG |-> prdata == {25'h0, cfg_q}) else $error("config readback");
  a_unmapped_err: assert property (pready && !(idx inside {`UBF_IDX_DATA, `UBF_IDX_STATUS,
    `UBF_IDX_LINE_CONFIG, `UBF_IDX_BAUD_PERIOD, `UBF_IDX_BAUD_FRACTION})
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_manual_rts: assert property (
    stab_q == 2'h3 && !cfg_q[6] |-> rx_ready_out_n == !cfg_q[0]) else $error("manual rts level");
  a_flow_hold: assert property (
    stab_q == 2'h3 && cfg_q[5] && tx_permit_in_n && tx_out |=> tx_out) else $error("sent unpermitted");
  c_refused: cover property (pready && pslverr);
  c_auto_rts: cover property (cfg_q[6] && !rx_ready_out_n);
  c_tx_start: cover property ($fell(tx_out));
endmodule
`default_nettype wire

// ===== test/ubf_peer.sv
/* Remote UART peer: sends frames on rx_in, takes frames from tx_out.
   Assumes the bench sets bt, the bit time in ns, before any frame. */
`timescale 1ns/10ps
`default_nettype none
module ubf_peer (
  input wire logic pclk,
  input wire logic tx_out,
  output logic rx_in,
  output logic tx_permit_in_n
);
  real bt = 1000.0;
  initial begin
    rx_in = 1'b1;
    tx_permit_in_n = 1'b0;
  end
  task automatic permit(input logic v);
    tx_permit_in_n <= v;
  endtask
  // bad flips the parity bit on purpose
  task automatic send(input logic [7:0] d, input logic par, input logic odd, input logic bad);
    logic [10:0] f;
    int nb;
    real t0;
    f = par ? {1'b1, ^d ^ odd ^ bad, d, 1'b0} : {2'h3, d, 1'b0};
    nb = par ? 11 : 10;
    t0 = $realtime;
    for (int i = 0; i <= nb; i++) begin
      while ($realtime < t0 + i * bt) @(posedge pclk);
      if (i < nb) rx_in <= f[i];
    end
  endtask
  // returns the stop bit above the data byte
  task automatic recv(output logic [8:0] d);
    int n;
    real t0;
    n = 0;
    while (tx_out !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    t0 = $realtime;
    for (int i = 0; i < 9; i++) begin
      while ($realtime < t0 + (i + 1.5) * bt) @(posedge pclk);
      d[i] = tx_out;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/test_ubf_top.sv
/* Bench of the UART config block: APB tasks, peer traffic, verdict.
   Assumes the peer and checker files are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "ubf_regs.svh"
module test_ubf_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rx_in, tx_out, permit_n, rts_n, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [8:0] b;
  int miscompares = 0;
  int n_tests = 0;
  always #20 pclk = ~pclk;
  ubf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .tx_permit_in_n(permit_n),
    .rx_ready_out_n(rts_n));
  ubf_peer u_peer (.pclk(pclk), .tx_out(tx_out), .rx_in(rx_in), .tx_permit_in_n(permit_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] i, input logic [31:0] x);
    xfer(1'b0, i, 32'h0);
    chk(r, x);
  endtask
  task automatic settle_rts(input logic x);
    repeat (3) @(posedge pclk);
    chk(rts_n, x);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`UBF_IDX_LINE_CONFIG, 32'h0);
    rdc(`UBF_IDX_BAUD_PERIOD, 32'h0);
    rdc(`UBF_IDX_BAUD_FRACTION, 32'h0);
    chk(rts_n, 1'b1);
    xfer(1'b1, `UBF_IDX_BAUD_FRACTION, 32'hFFFFFFFF);
    rdc(`UBF_IDX_BAUD_FRACTION, 32'h1);
    xfer(1'b1, `UBF_IDX_BAUD_PERIOD, 32'hFFFFFFFF);
    rdc(`UBF_IDX_BAUD_PERIOD, 32'hFFFF);
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'hFFFFFFFF);
    rdc(`UBF_IDX_LINE_CONFIG, 32'h7F);
    rdc(16'h4400, 32'h0);
    chk(e, 1'b1);
    for (int v = 0; v < 2; v++) begin
      xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h2 | v);
      settle_rts(!v[0]);
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(`UBF_IDX_LINE_CONFIG, 32'h0);
    chk(rts_n, 1'b1);
    $display("test registers done");
    xfer(1'b1, `UBF_IDX_BAUD_PERIOD, 32'h4);
    xfer(1'b1, `UBF_IDX_BAUD_FRACTION, 32'h1);
    u_peer.bt = (2 * 4 + 1) * 1000.0 / `UBF_REF_MHZ;
    for (int o = 0; o < 2; o++) begin
      xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'hA | (o << 4));
      u_peer.send(8'hA5 ^ o[7:0], 1'b1, o[0], 1'b0);
      rdc(`UBF_IDX_DATA, 32'hA5 ^ o);
      u_peer.send(8'h5A, 1'b1, o[0], 1'b1);
      xfer(1'b0, `UBF_IDX_STATUS, 32'h0);
      chk(r[`UBF_ST_PAR_ERR], 1'b1);
      xfer(1'b1, `UBF_IDX_STATUS, 32'h20);
      xfer(1'b0, `UBF_IDX_DATA, 32'h0);
      rdc(`UBF_IDX_STATUS, 32'h45);
    end
    $display("test parity done");
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h42);
    settle_rts(1'b0);
    for (int k = 0; k < 2; k++) begin
      u_peer.send(8'h10 + k[7:0], 1'b0, 1'b0, 1'b0);
      settle_rts(1'b0);
    end
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h43);
    u_peer.send(8'h12, 1'b0, 1'b0, 1'b0);
    settle_rts(1'b1);
    rdc(`UBF_IDX_DATA, 32'h10);
    settle_rts(1'b0);
    for (int k = 1; k < 3; k++) rdc(`UBF_IDX_DATA, 32'h10 + k);
    $display("test auto rts done");
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h22);
    u_peer.permit(1'b1);
    xfer(1'b1, `UBF_IDX_DATA, 32'h3C);
    repeat (200) @(posedge pclk);
    chk(tx_out, 1'b1);
    u_peer.permit(1'b0);
    u_peer.recv(b);
    chk(b, 9'h13C);
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h2);
    u_peer.permit(1'b1);
    xfer(1'b1, `UBF_IDX_DATA, 32'hC3);
    u_peer.recv(b);
    chk(b, 9'h1C3);
    xfer(1'b1, `UBF_IDX_LINE_CONFIG, 32'h1C);
    xfer(1'b1, `UBF_IDX_DATA, 32'hD5);
    u_peer.recv(b);
    chk(b, 9'h1D5);
    $display("test transmit done");
    report_and_stop;
  end
endmodule
bind ubf_top ubf_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
  .tx_permit_in_n(tx_permit_in_n), .rx_ready_out_n(rx_ready_out_n));
`default_nettype wire
